/* src/ssl_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module ssl_fifo
  import ssl_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
)
(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side.
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem_ff[rd_ptr_ff];

  // Storage array write.
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop)
      begin
        count_ff <= count_ff + 1'b1;
      end
      else if (pop && !push)
      begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // A full FIFO must refuse new words, so the count can never pass the depth.
  AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk_i) disable iff (rst_i)
    (count_ff <= (AW+1)'(DEPTH)))
    else $error("FIFO accepts a word while full.");
endmodule : ssl_fifo
`default_nettype wire

/* src/ssl_pkg.sv */
// Package with widths, reset values and pin encodings for the shift and storage latch.
package ssl_pkg;
  localparam int unsigned   SSL_WIDTH        = 8;
  localparam int unsigned   SSL_FIFO_DEPTH   = 16;
  localparam logic [7:0]    SSL_SHIFT_CLR    = 8'h00;
  localparam logic [7:0]    SSL_STORE_RST    = 8'h00;
  localparam logic [1:0]    SSL_SYNC_RST     = 2'h0;
  localparam logic          SSL_LVL_LOW      = 1'h0;
  localparam logic          SSL_LVL_HIGH     = 1'h1;
endpackage : ssl_pkg

/* src/ssl_top.sv */
// Serial-in shift register feeding a storage register with three-state parallel outputs.
`timescale 1ns/1ps
`default_nettype none
module ssl_top
  import ssl_pkg::*;
#(
  parameter int unsigned WIDTH      = SSL_WIDTH,
  parameter int unsigned FIFO_DEPTH = SSL_FIFO_DEPTH
)
(
  // Clock and reset.
  input  wire logic             SYS_CLK_I,
  input  wire logic             SYS_RST_I,
  // Host pins, asynchronous to the system clock.
  input  wire logic             SERIAL_DATA_IN_I,
  input  wire logic             SHIFT_CLOCK_I,
  input  wire logic             STORE_CLOCK_I,
  input  wire logic             SHIFT_CLEAR_N_I,
  input  wire logic             OUTPUT_ENABLE_N_I,
  // Three-state parallel outputs.
  output logic      [WIDTH-1:0] PARALLEL_OUT_O,
  output logic      [WIDTH-1:0] PARALLEL_OUT_OE_O,
  // Cascade output toward the next device.
  output logic                  SERIAL_CASCADE_OUT_O,
  // Stream of latched words for on-chip consumers.
  output logic                  WORD_VALID_O,
  input  wire logic             WORD_READY_I,
  output logic      [WIDTH-1:0] WORD_DATA_O,
  // High while the word FIFO cannot take a new latch event.
  output logic                  WORD_STALL_O
);
  typedef enum logic [2:0]
  {
    SSL_ST_IDLE  = 3'b001,
    SSL_ST_RUN   = 3'b010,
    SSL_ST_CLEAR = 3'b100
  } ssl_state_t;

  // Two-stage synchronisers for each pin; the first stage feeds only the second.
  logic [1:0] ser_sync_ff;
  logic [1:0] shclk_sync_ff;
  logic [1:0] stclk_sync_ff;
  logic [1:0] clr_sync_ff;
  logic [1:0] oe_sync_ff;
  logic       shclk_prev_ff;
  logic       stclk_prev_ff;
  logic       shift_rise;
  logic       store_rise;
  logic       clear_act;
  logic       ser_lvl;

  logic [WIDTH-1:0] shift_ff;
  logic [WIDTH-1:0] nxt_shift;
  logic [WIDTH-1:0] store_ff;
  logic [WIDTH-1:0] nxt_store;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] oe_ff;
  logic             cascade_ff;
  ssl_state_t       state_ff;
  ssl_state_t       nxt_state;
  logic             fifo_ready;

  // Pin synchronisers. Every pin effect lands three system cycles late; the host
  // must hold each pin level for at least one whole cycle or an edge can be lost.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ser_sync_ff   <= SSL_SYNC_RST;
      shclk_sync_ff <= SSL_SYNC_RST;
      stclk_sync_ff <= SSL_SYNC_RST;
      clr_sync_ff   <= {SSL_LVL_HIGH, SSL_LVL_HIGH};
      oe_sync_ff    <= {SSL_LVL_HIGH, SSL_LVL_HIGH};
    end
    else
    begin
      ser_sync_ff   <= {ser_sync_ff[0], SERIAL_DATA_IN_I};
      shclk_sync_ff <= {shclk_sync_ff[0], SHIFT_CLOCK_I};
      stclk_sync_ff <= {stclk_sync_ff[0], STORE_CLOCK_I};
      clr_sync_ff   <= {clr_sync_ff[0], SHIFT_CLEAR_N_I};
      oe_sync_ff    <= {oe_sync_ff[0], OUTPUT_ENABLE_N_I};
    end
  end

  // Previous clock levels for rising edge detection on synchronised copies.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      shclk_prev_ff <= SSL_LVL_LOW;
      stclk_prev_ff <= SSL_LVL_LOW;
    end
    else
    begin
      shclk_prev_ff <= shclk_sync_ff[1];
      stclk_prev_ff <= stclk_sync_ff[1];
    end
  end

  // Edge and level decode. Data passes the same two stages as the clock, so the
  // host's setup time before the shift edge is preserved after synchronisation.
  assign shift_rise = shclk_sync_ff[1] & ~shclk_prev_ff;
  assign store_rise = stclk_sync_ff[1] & ~stclk_prev_ff;
  assign clear_act  = ~clr_sync_ff[1];
  assign ser_lvl    = ser_sync_ff[1];

  // Next shift register value.
  always_comb
  begin
    nxt_shift = shift_ff;
    if (clear_act)
    begin
      nxt_shift = SSL_SHIFT_CLR;
    end
    else if (shift_rise)
    begin
      nxt_shift = {shift_ff[WIDTH-2:0], ser_lvl};
    end
  end

  // Shift register.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      shift_ff <= SSL_SHIFT_CLR;
    end
    else
    begin
      shift_ff <= nxt_shift;
    end
  end

  // Storage copies the current shift contents, i.e. the value before any
  // shift taken on this same edge; clear and shift edges leave it alone.
  always_comb
  begin
    nxt_store = store_ff;
    if (store_rise)
    begin
      nxt_store = shift_ff;
    end
  end

  // Storage register.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      store_ff <= SSL_STORE_RST;
    end
    else
    begin
      store_ff <= nxt_store;
    end
  end

  // Parallel output drivers; enables follow the synchronised enable pin.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      out_ff <= SSL_STORE_RST;
      oe_ff  <= '0;
    end
    else
    begin
      out_ff <= nxt_store;
      oe_ff  <= {WIDTH{~oe_sync_ff[1]}};
    end
  end

  // Cascade output comes from the last stage only, never gated by the enable.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      cascade_ff <= SSL_LVL_LOW;
    end
    else
    begin
      cascade_ff <= nxt_shift[WIDTH-1];
    end
  end

  assign PARALLEL_OUT_O       = out_ff;
  assign PARALLEL_OUT_OE_O    = oe_ff;
  assign SERIAL_CASCADE_OUT_O = cascade_ff;

  // Activity monitor: tracks whether the host has cleared the chain and is running.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      SSL_ST_IDLE:  if (clear_act) nxt_state = SSL_ST_CLEAR;
      SSL_ST_CLEAR: if (!clear_act && store_rise) nxt_state = SSL_ST_RUN;
      SSL_ST_RUN:   if (clear_act) nxt_state = SSL_ST_CLEAR;
      default:      nxt_state = SSL_ST_IDLE;
    endcase
  end

  // Monitor state register.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      state_ff <= SSL_ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Every latched word is offered to the on-chip stream. A full FIFO drops
  // nothing silently: the stall flag tells the host to slow its storage edges.
  ssl_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (SYS_CLK_I),
    .rst_i       (SYS_RST_I),
    .in_valid_i  (store_rise),
    .in_ready_o  (fifo_ready),
    .in_data_i   (shift_ff),
    .out_valid_o (WORD_VALID_O),
    .out_ready_i (WORD_READY_I),
    .out_data_o  (WORD_DATA_O)
  );

  assign WORD_STALL_O = ~fifo_ready;

  AST_OE_FLOAT: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    oe_sync_ff[1] |=> (PARALLEL_OUT_OE_O == '0))
    else $error("Outputs driven while enable pin is high.");

  AST_OE_DRIVE: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !oe_sync_ff[1] |=> (&PARALLEL_OUT_OE_O && PARALLEL_OUT_O == store_ff))
    else $error("Outputs not driven with storage contents.");

  AST_CLEAR_ZERO: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    clear_act |=> (shift_ff == '0))
    else $error("Shift register not zero under clear.");

  AST_SHIFT_MOVE: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (shift_rise && !clear_act) |=>
      (shift_ff == {$past(shift_ff[WIDTH-2:0]), $past(ser_lvl)}))
    else $error("Shift edge did not move the stages.");

  AST_STORE_COPY: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    store_rise |=> (store_ff == $past(shift_ff)))
    else $error("Storage edge did not copy the shift stages.");

  AST_SAME_EDGE: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (store_rise && shift_rise && !clear_act) |=>
      (store_ff == $past(shift_ff)) &&
      (shift_ff == {$past(shift_ff[WIDTH-2:0]), $past(ser_lvl)}))
    else $error("Simultaneous edges stored post-shift data.");

  AST_SHIFT_KEEPS_STORE: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !store_rise |=> $stable(store_ff))
    else $error("Storage changed without a storage edge.");

  AST_CLEAR_KEEPS_OUT: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (clear_act && !store_rise) ##1 !store_rise |=> $stable(PARALLEL_OUT_O))
    else $error("Clear disturbed the parallel outputs.");

  AST_CASCADE_LAST: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    1'b1 |-> (SERIAL_CASCADE_OUT_O == shift_ff[WIDTH-1]))
    else $error("Cascade output differs from last stage.");

  AST_SHIFT_HOLD: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (!shift_rise && !clear_act) |=> $stable(shift_ff))
    else $error("Shift stages moved without a shift edge.");

  AST_INIT_DEFINED: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (state_ff == SSL_ST_CLEAR && !clear_act && store_rise && shift_ff == '0) |=>
      (store_ff == '0 && state_ff == SSL_ST_RUN))
    else $error("Storage edge after clear gave no defined word.");

  COV_SHIFT: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    shift_rise && !clear_act);
  COV_STORE: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) store_rise);
  COV_SAME: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    shift_rise && store_rise);
  COV_INIT: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    state_ff == SSL_ST_CLEAR ##[1:50] state_ff == SSL_ST_RUN);
  COV_OE_TOGGLE: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    oe_sync_ff[1] ##1 !oe_sync_ff[1]);
endmodule : ssl_top
`default_nettype wire

/* tb/ssl_host_model.sv */
// Host model: general-purpose pins that drive the shift and storage latch.
`timescale 1ns/1ps
`default_nettype none
module ssl_host_model
  import ssl_pkg::*;
(
  // Clock.
  input  wire logic clk_i,
  // Pins toward the latch.
  output logic      ser_o,
  output logic      shift_clk_o,
  output logic      store_clk_o,
  output logic      clear_n_o,
  output logic      oe_n_o
);
  // Outputs start disabled so nothing undefined reaches the pads.
  initial
  begin
    ser_o       = SSL_LVL_LOW;
    shift_clk_o = SSL_LVL_LOW;
    store_clk_o = SSL_LVL_LOW;
    clear_n_o   = SSL_LVL_HIGH;
    oe_n_o      = SSL_LVL_HIGH;
  end

  // Every pin level lasts whole cycles.
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold

  // Data settles three cycles before the edges and stays three after.
  task automatic pulse(input logic sh, input logic st, input logic b);
    ser_o <= b;
    hold(3);
    shift_clk_o <= sh;
    store_clk_o <= st;
    hold(3);
    shift_clk_o <= SSL_LVL_LOW;
    store_clk_o <= SSL_LVL_LOW;
    ser_o       <= ~b;  // Released data shows the inverse, not a stale level.
    hold(3);
  endtask : pulse

  // Clear first so that a later storage edge gives a defined word.
  task automatic clear(input logic sh);
    clear_n_o <= SSL_LVL_LOW;
    hold(3);
    pulse(sh, SSL_LVL_LOW, SSL_LVL_HIGH);
    clear_n_o <= SSL_LVL_HIGH;
    hold(3);
  endtask : clear

  // Enable changes reach the pads in the same three cycles as stored data.
  task automatic set_oe(input logic v);
    oe_n_o <= v;
    hold(5);
  endtask : set_oe
endmodule : ssl_host_model
`default_nettype wire

/* tb/test_ssl_top.sv */
// Self-checking testbench for the shift and storage latch.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module test_ssl_top
  import ssl_pkg::*;
;
  logic       sys_clk, sys_rst, serial_data_in, sh_clk, st_clk, clr_n, oe_n;
  logic       word_ready, casc, casc2, wvalid, stall;
  logic [7:0] pout, poe, wdata, sh_e, st_e, w;
  logic [7:0] pout2, sh2_e, st2_e, oe_e;
  logic [7:0] q[$];
  int         err_total, compares;

  // Free-running system clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  ssl_top ssl_top_i (.SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .SERIAL_DATA_IN_I(serial_data_in),
    .SHIFT_CLOCK_I(sh_clk), .STORE_CLOCK_I(st_clk), .SHIFT_CLEAR_N_I(clr_n),
    .OUTPUT_ENABLE_N_I(oe_n), .PARALLEL_OUT_O(pout), .PARALLEL_OUT_OE_O(poe),
    .SERIAL_CASCADE_OUT_O(casc), .WORD_VALID_O(wvalid), .WORD_READY_I(word_ready),
    .WORD_DATA_O(wdata), .WORD_STALL_O(stall));
  ssl_host_model ssl_host_model_i (.clk_i(sys_clk), .ser_o(serial_data_in), .shift_clk_o(sh_clk),
    .store_clk_o(st_clk), .clear_n_o(clr_n), .oe_n_o(oe_n));
  // A second latch hangs off the cascade output and shares every clock and control.
  ssl_top ssl_top_next_i (.SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .SERIAL_DATA_IN_I(casc),
    .SHIFT_CLOCK_I(sh_clk), .STORE_CLOCK_I(st_clk), .SHIFT_CLEAR_N_I(clr_n),
    .OUTPUT_ENABLE_N_I(oe_n), .PARALLEL_OUT_O(pout2), .PARALLEL_OUT_OE_O(),
    .SERIAL_CASCADE_OUT_O(casc2), .WORD_VALID_O(), .WORD_READY_I(word_ready),
    .WORD_DATA_O(), .WORD_STALL_O());

  task automatic give_verdict();
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Pins are sampled mid-cycle so no edge race decides the outcome.
  task automatic check_pins(input logic [7:0] oe_exp);
    @(negedge sys_clk);
    `CHK("enable", oe_exp, poe)
    `CHK("parallel", st_e, pout)
    `CHK("cascade", sh_e[7], casc)
    `CHK("chained cascade", sh2_e[7], casc2)
    `CHK("chained parallel", st2_e, pout2)
    @(posedge sys_clk);
  endtask : check_pins

  task automatic shift_in(input logic b);
    ssl_host_model_i.pulse(1'b1, 1'b0, b);
    sh2_e = {sh2_e[6:0], sh_e[7]};
    sh_e = {sh_e[6:0], b};
    check_pins(oe_e);
  endtask : shift_in

  task automatic shift_word(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      shift_in(v[i]);
  endtask : shift_word

  // A shift edge may coincide; storage must take the pre-shift word.
  task automatic store(input logic sh);
    ssl_host_model_i.pulse(sh, 1'b1, 1'b1);
    st_e = sh_e;
    st2_e = sh2_e;
    if (sh)
    begin
      sh2_e = {sh2_e[6:0], sh_e[7]};
      sh_e = {sh_e[6:0], 1'b1};
    end
    if (q.size() < SSL_FIFO_DEPTH)
      q.push_back(st_e);
    check_pins(oe_e);
  endtask : store

  task automatic t_init();
    ssl_host_model_i.clear(1'b0);
    sh_e = SSL_SHIFT_CLR;
    sh2_e = SSL_SHIFT_CLR;
    store(1'b0);
    check_pins(8'h00);
    ssl_host_model_i.set_oe(1'b0);
    oe_e = 8'hff;
    check_pins(8'hff);
  endtask : t_init

  // Clear with a shift edge inside it; storage keeps its word.
  task automatic t_clear();
    ssl_host_model_i.clear(1'b1);
    sh_e = SSL_SHIFT_CLR;
    sh2_e = SSL_SHIFT_CLR;
    check_pins(8'hff);
    store(1'b0);
  endtask : t_clear

  task automatic t_oe();
    ssl_host_model_i.set_oe(1'b1);
    oe_e = 8'h00;
    check_pins(oe_e);
    ssl_host_model_i.set_oe(1'b0);
    oe_e = 8'hff;
    check_pins(oe_e);
  endtask : t_oe

  // Fill the word queue with the consumer stalled, overflow once, then drain.
  task automatic t_fifo();
    while (q.size() < SSL_FIFO_DEPTH)
      store(1'b0);
    @(negedge sys_clk);
    `CHK("stall", 1'b1, stall)
    store(1'b0);
    for (int i = 0; i < SSL_FIFO_DEPTH; i++)
    begin
      @(negedge sys_clk);
      w = q.pop_front();
      `CHK("valid", 1'b1, wvalid)
      `CHK("word", w, wdata)
      @(posedge sys_clk);
      word_ready <= 1'b1;
      @(posedge sys_clk);
      word_ready <= 1'b0;
    end
    @(negedge sys_clk);
    `CHK("valid", 1'b0, wvalid)
    `CHK("stall", 1'b0, stall)
  endtask : t_fifo

  // Main sequence.
  initial
  begin
    sys_rst    = 1'b1;
    word_ready = 1'b0;
    sh_e       = SSL_SHIFT_CLR;
    st_e       = SSL_STORE_RST;
    sh2_e      = SSL_SHIFT_CLR;
    st2_e      = SSL_STORE_RST;
    oe_e       = 8'h00;
    err_total  = 0;
    compares   = 0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_init();
    shift_word(8'ha5);
    store(1'b0);
    t_clear();
    shift_word(8'h3c);
    store(1'b1);
    shift_word(8'h96);
    store(1'b0);
    t_oe();
    t_fifo();
    give_verdict();
  end

  // Watchdog: the run needs under a thousand cycles.
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end
endmodule : test_ssl_top
`default_nettype wire
